// >>> src/qeac_axis_card.sv
// Four-axis incremental position card: decoders, counters, probe latch,
// read watchdog and the passive backplane bus slave.
// Assumes all pins are asynchronous to i_clk and the bus holds address and
// data stable while its strobes stand.
//
// Behaviour
// - A04..A03 select axis one to four
// - A02..A01 select function; A00 must be zero
// - Card fills 32-byte window above switch base
// - Status byte reports six active-high conditions
// - Status bits zero and two read zero
// - Non-saving watchdog flags bit and LED, clears set values
// - Saving watchdog latches until status write rearms
// - Any actual-value read retriggers the watchdog
// - Measuring-value reads never retrigger the watchdog
// - Probe polarity selectable; active level fires immediately
// - Four counting modes per axis decoder
// - Measuring read resets measuring logic; host does one
// - Status write bit two arms one measurement
// - Trigger freezes all four axes at once
// - Frozen axis returns capture until measuring read
// - Measuring read clears result-ready bit three
// - Rearm needs one measuring read; unread captures kept
// - Early measuring read cancels armed measurement
// - Zero mark clears counter during reference move
// - Counter mode: actual read returns then clears
// - Counter mode: track-b change stops until reset
// - Sixteen-bit up/down counter wrapping without carry
// - Position-mode actual read leaves counter intact
// - Watchdog trip clears all set values
`timescale 1ns/1ps

module qeac_axis_card
  import qeac_pkg::*;
#(
  parameter int WD_CYCLES = WD_CYCLES_DEF
) (
  // Clock, reset, enable
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_clk_en,
  // Backplane bus pins
  input wire logic [15:0] i_bus_addr,
  input wire logic [15:0] i_bus_data,
  input wire logic i_bus_valid,
  input wire logic i_bus_rd,
  input wire logic i_bus_wr,
  input wire logic i_bus_reset,
  output logic [15:0] o_bus_data,
  output logic o_bus_data_oe,
  output logic o_bus_rdy,
  // Switches and straps
  input wire logic [7:0] i_base_addr_switch,
  input wire logic i_wd_mode_strap,
  input wire logic i_probe_polarity_strap,
  input wire logic [AXIS_N-1:0][1:0] i_count_mode,
  // Encoder side
  input wire qeac_enc_type [AXIS_N-1:0] i_axis_enc,
  input wire logic i_probe_trigger_in,
  // Outputs to the machine
  output logic o_health_led,
  output logic [AXIS_N-1:0][15:0] o_set_value
);

  ////////////////////////////////////////////////////////////////////////////
  // Counting step: {enable, up} from old and new track levels
  function automatic logic [1:0] qeac_step(input logic [1:0] mode, input logic a_o,
                                           input logic b_o, input logic a_n,
                                           input logic b_n);
    logic [1:0] res;
    res = 2'h0;
    case (mode)
      MODE_QUAD4: res = {(a_o ^ a_n) | (b_o ^ b_n), a_n ^ b_o};
      MODE_DOUBLE_A: res = {a_o ^ a_n, a_n ^ b_n};
      MODE_SINGLE_A: res = {~a_o & a_n, ~b_n};
      default: res = {~a_o & a_n, 1'b1};
    endcase
    return res;
  endfunction : qeac_step

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  qeac_bus_type bus_s1_q;
  qeac_bus_type bus_s2_q;
  qeac_enc_type [AXIS_N-1:0] enc_s1_q;
  qeac_enc_type [AXIS_N-1:0] enc_s2_q;
  qeac_enc_type [AXIS_N-1:0] enc_s3_q;
  logic [11:0] cfg_s1_q;
  logic [11:0] cfg_s2_q;
  logic [1:0] probe_s1_q;
  logic [1:0] probe_s2_q;
  logic bus_rst_prev_q;
  // Pipe fill marker: the history stage is only trusted once refilled
  logic [2:0] sync_fill_q;
  wire enc_live = sync_fill_q[2];

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      bus_s1_q <= '0;
      bus_s2_q <= '0;
      cfg_s1_q <= '0;
      cfg_s2_q <= '0;
      probe_s1_q <= '0;
      probe_s2_q <= '0;
    end else if (i_clk_en) begin
      bus_s1_q <= {i_bus_addr, i_bus_data, i_bus_valid, i_bus_rd, i_bus_wr, i_bus_reset};
      bus_s2_q <= bus_s1_q;
      cfg_s1_q <= {i_base_addr_switch, i_wd_mode_strap, i_probe_polarity_strap, 2'h0};
      cfg_s2_q <= cfg_s1_q;
      probe_s1_q <= {i_probe_trigger_in, 1'b0};
      probe_s2_q <= probe_s1_q;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      enc_s1_q <= '0;
      enc_s2_q <= '0;
      enc_s3_q <= '0;
      bus_rst_prev_q <= 1'b0;
      sync_fill_q <= '0;
    end else if (i_clk_en) begin
      sync_fill_q <= {sync_fill_q[1:0], 1'b1};
      enc_s1_q <= i_axis_enc;
      enc_s2_q <= enc_s1_q;
      enc_s3_q <= enc_s2_q;
      bus_rst_prev_q <= bus_s2_q.rst;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Address decode
  wire [7:0] base_sw = cfg_s2_q[11:4];
  wire wd_saving = cfg_s2_q[3];
  wire probe_pol_rise = cfg_s2_q[2];
  wire [1:0] acc_axis = bus_s2_q.addr[AXIS_HI:AXIS_LO];
  wire [1:0] acc_fn = bus_s2_q.addr[FN_HI:FN_LO];
  wire strobe = bus_s2_q.valid & (bus_s2_q.rd | bus_s2_q.wr);
  wire addr_hit = (bus_s2_q.addr[AREA_HI:AREA_LO] == AREA_CODE) &&
                  (bus_s2_q.addr[BASE_HI:BASE_LO] == base_sw) &&
                  !bus_s2_q.addr[ALIGN_BIT];
  wire bus_sel = strobe & addr_hit;

  qeac_bus_state_type bus_state_q;
  qeac_bus_state_type bus_state_d;

  always_comb begin
    bus_state_d = bus_state_q;
    case (bus_state_q)
      BUS_IDLE: begin
        if (bus_sel) begin
          bus_state_d = BUS_ACT;
        end
      end
      BUS_ACT: bus_state_d = BUS_HOLD;
      BUS_HOLD: begin
        if (!strobe) begin
          bus_state_d = BUS_IDLE;
        end
      end
      default: bus_state_d = BUS_IDLE;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      bus_state_q <= BUS_IDLE;
    end else if (i_clk_en) begin
      bus_state_q <= bus_state_d;
    end
  end

  // One-cycle access strobes; side effects happen only here
  wire acc_go = (bus_state_q == BUS_ACT);
  wire acc_rd = acc_go & bus_s2_q.rd;
  wire acc_wr = acc_go & bus_s2_q.wr & ~bus_s2_q.rd;
  wire [AXIS_N-1:0] axis_hit = acc_go ? (4'h1 << acc_axis) : 4'h0;
  wire rd_status = acc_rd & (acc_fn == FN_STATUS);
  wire rd_actual = acc_rd & (acc_fn == FN_ACTUAL);
  wire rd_meas = acc_rd & (acc_fn == FN_MEAS);
  wire wr_status = acc_wr & (acc_fn == FN_STATUS);
  wire wr_set = acc_wr & (acc_fn == FN_SET);
  wire bus_soft_rst = bus_s2_q.rst & ~bus_rst_prev_q;

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog
  logic [31:0] wd_cnt_q;
  logic wd_armed_q;
  logic wd_trip_q;
  wire wd_expire = wd_armed_q && (wd_cnt_q == WD_ONE) && !rd_actual;
  wire wd_trip_evt = wd_expire & ~wd_trip_q;

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      wd_cnt_q <= WD_ONE;
      wd_armed_q <= 1'b0;
      wd_trip_q <= 1'b0;
    end else if (i_clk_en) begin
      if (rd_actual) begin
        wd_cnt_q <= 32'(WD_CYCLES);
      end else if (wd_cnt_q != WD_ONE) begin
        wd_cnt_q <= wd_cnt_q - WD_ONE;
      end
      if (wd_saving) begin
        // latched trip, rearmed by a status write
        if (wd_expire) begin
          wd_trip_q <= 1'b1;
          wd_armed_q <= 1'b0;
        end else if (wr_status) begin
          wd_trip_q <= 1'b0;
          wd_armed_q <= 1'b1;
        end
      end else begin
        // flag not latched, clears on next actual read
        wd_armed_q <= 1'b1;
        if (wd_expire) begin
          wd_trip_q <= 1'b1;
        end else if (rd_actual) begin
          wd_trip_q <= 1'b0;
        end
      end
    end
  end

  assign o_health_led = ~wd_trip_q;

  ////////////////////////////////////////////////////////////////////////////
  // Touch probe and measuring control
  logic meas_armed_q;
  logic rearm_ok_q;
  logic [AXIS_N-1:0] frozen_q;
  // level check fires at once if already active
  wire probe_active = probe_pol_rise ? probe_s2_q[1] : ~probe_s2_q[1];
  wire fire = meas_armed_q & probe_active & ~rd_meas;
  wire arm_req = wr_status & bus_s2_q.data[ST_ARM_MEASURE] & rearm_ok_q;

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      meas_armed_q <= 1'b0;
      rearm_ok_q <= 1'b1;
    end else if (i_clk_en) begin
      if (rd_meas) begin
        // early read cancels; read resets logic
        meas_armed_q <= 1'b0;
        rearm_ok_q <= 1'b1;
      end else if (fire) begin
        meas_armed_q <= 1'b0;
        rearm_ok_q <= 1'b0;
      end else if (arm_req) begin
        meas_armed_q <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Axis datapath
  logic [AXIS_N-1:0][15:0] cnt_q;
  logic [AXIS_N-1:0][15:0] meas_q;
  logic [AXIS_N-1:0][15:0] set_q;
  logic [AXIS_N-1:0] ref_act_q;
  logic [AXIS_N-1:0] ref_done_q;
  logic [AXIS_N-1:0] stop_q;
  logic [AXIS_N-1:0] cnt_en;
  logic [AXIS_N-1:0] cnt_up;
  logic [AXIS_N-1:0] zero_rise;
  logic [AXIS_N-1:0] is_ctr;
  logic [AXIS_N-1:0][7:0] status_rd;

  for (genvar g = 0; g < AXIS_N; g++) begin : g_axis
    wire [1:0] step = qeac_step(i_count_mode[g], enc_s3_q[g].track_a, enc_s3_q[g].track_b,
                                enc_s2_q[g].track_a, enc_s2_q[g].track_b);
    assign is_ctr[g] = (i_count_mode[g] == MODE_COUNTER);
    // counter mode gated by track-b enable and stop
    // Gated until refilled, so reset zeros never read as pin edges
    assign cnt_en[g] = enc_live & step[1] &
                       (~is_ctr[g] | (enc_s2_q[g].track_b & ~stop_q[g]));
    assign cnt_up[g] = step[0];
    assign zero_rise[g] = enc_live & enc_s2_q[g].zero_mark & ~enc_s3_q[g].zero_mark;
    // status byte layout; bits 0 and 2 read zero
    assign status_rd[g] = {wd_trip_q, enc_s2_q[g].brk_b, enc_s2_q[g].brk_a,
                           enc_s2_q[g].fault, frozen_q[g], 1'b0, ref_done_q[g], 1'b0};
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      cnt_q <= '0;
      meas_q <= '0;
      set_q <= '0;
      ref_act_q <= '0;
      ref_done_q <= '0;
      stop_q <= '0;
      frozen_q <= '0;
    end else if (i_clk_en) begin
      for (int i = 0; i < AXIS_N; i++) begin
        if (cnt_en[i]) begin
          cnt_q[i] <= cnt_up[i] ? cnt_q[i] + CNT_ONE : cnt_q[i] - CNT_ONE;
        end
        if (bus_soft_rst) begin
          cnt_q[i] <= CNT_RESET;
        end else if (zero_rise[i] && (ref_act_q[i] || is_ctr[i])) begin
          // zero mark clears through reset path
          cnt_q[i] <= CNT_RESET;
        end else if (rd_actual && axis_hit[i] && is_ctr[i] && !frozen_q[i]) begin
          // read then clear, a same-cycle pulse kept
          cnt_q[i] <= cnt_en[i] ? CNT_ONE : CNT_RESET;
        end
        // track-b change stops; restored level plus reset resumes
        if (enc_live && is_ctr[i] && (enc_s2_q[i].track_b != enc_s3_q[i].track_b)) begin
          stop_q[i] <= 1'b1;
        end else if ((bus_soft_rst || zero_rise[i]) && enc_s2_q[i].track_b) begin
          stop_q[i] <= 1'b0;
        end
        // Reference move: bit 0 write starts, zero mark completes
        if (zero_rise[i] && ref_act_q[i]) begin
          ref_act_q[i] <= 1'b0;
          ref_done_q[i] <= 1'b1;
        end else if (wr_status && axis_hit[i] && bus_s2_q.data[ST_REF_ACTIVE]) begin
          ref_act_q[i] <= 1'b1;
          ref_done_q[i] <= 1'b0;
        end
        if (fire && !frozen_q[i]) begin
          meas_q[i] <= cnt_q[i];
          frozen_q[i] <= 1'b1;
        end else if (rd_meas && axis_hit[i]) begin
          // measuring read clears ready and releases
          frozen_q[i] <= 1'b0;
        end
        if (wd_trip_evt) begin
          set_q[i] <= CNT_RESET;
        end else if (wr_set && axis_hit[i]) begin
          set_q[i] <= bus_s2_q.data;
        end
      end
    end
  end

  assign o_set_value = set_q;

  ////////////////////////////////////////////////////////////////////////////
  // Read data
  // frozen axis returns capture; actual read keeps it frozen
  wire [15:0] actual_rd = frozen_q[acc_axis] ? meas_q[acc_axis] : cnt_q[acc_axis];
  wire [15:0] rd_word = rd_status ? {8'h00, status_rd[acc_axis]} :
                        rd_actual ? actual_rd :
                        rd_meas ? meas_q[acc_axis] : CNT_RESET;
  logic [15:0] rdata_q;
  logic rd_drive_q;

  // measuring reads touch no watchdog state
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      rdata_q <= CNT_RESET;
      rd_drive_q <= 1'b0;
    end else if (i_clk_en) begin
      if (acc_rd) begin
        rdata_q <= rd_word;
        rd_drive_q <= 1'b1;
      end else if (bus_state_d == BUS_IDLE) begin
        rd_drive_q <= 1'b0;
      end
    end
  end

  // Data lines driven only in the hold phase of a read
  assign o_bus_data = rdata_q;
  assign o_bus_data_oe = rd_drive_q & (bus_state_q == BUS_HOLD);
  assign o_bus_rdy = (bus_state_q == BUS_HOLD);

endmodule : qeac_axis_card

// >>> src/qeac_pkg.sv
// Constants, field layout and carrier types of the four-axis encoder card.
// Assumes one 50 MHz clock; every user sees this package by wildcard import.
package qeac_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Sizes and timing
  localparam int AXIS_N = 4;
  localparam int CNT_W = 16;
  localparam int CLK_MHZ = 50;
  localparam int WD_TIME_US = 20000;
  localparam int WD_CYCLES_DEF = WD_TIME_US * CLK_MHZ;

  ////////////////////////////////////////////////////////////////////////////
  // Address layout of the backplane bus
  localparam logic [2:0] AREA_CODE = 3'h7;
  localparam int AREA_HI = 15;
  localparam int AREA_LO = 13;
  localparam int BASE_HI = 12;
  localparam int BASE_LO = 5;
  localparam int AXIS_HI = 4;
  localparam int AXIS_LO = 3;
  localparam int FN_HI = 2;
  localparam int FN_LO = 1;
  localparam int ALIGN_BIT = 0;
  localparam logic [1:0] FN_STATUS = 2'h0;
  localparam logic [1:0] FN_ACTUAL = 2'h1;
  localparam logic [1:0] FN_SET = 2'h2;
  localparam logic [1:0] FN_MEAS = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // Status byte fields
  localparam int ST_REF_ACTIVE = 0;
  localparam int ST_REF_REACHED = 1;
  localparam int ST_ARM_MEASURE = 2;
  localparam int ST_RESULT_READY = 3;
  localparam int ST_ENC_FAULT = 4;
  localparam int ST_BREAK_A = 5;
  localparam int ST_BREAK_B = 6;
  localparam int ST_WD_TRIPPED = 7;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [15:0] CNT_RESET = 16'h0000;
  localparam logic [15:0] CNT_ONE = 16'h0001;
  localparam logic [31:0] WD_ONE = 32'h0000_0001;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [1:0] {
    MODE_QUAD4 = 2'h0,
    MODE_DOUBLE_A = 2'h1,
    MODE_SINGLE_A = 2'h2,
    MODE_COUNTER = 2'h3
  } qeac_mode_type;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'h0,
    BUS_ACT = 2'h1,
    BUS_HOLD = 2'h3
  } qeac_bus_state_type;

  typedef struct packed {
    logic fault;
    logic brk_b;
    logic brk_a;
    logic zero_mark;
    logic track_b;
    logic track_a;
  } qeac_enc_type;

  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] data;
    logic valid;
    logic rd;
    logic wr;
    logic rst;
  } qeac_bus_type;

endpackage : qeac_pkg

// >>> bench/qeac_chk.sv
// Assertions on the encoder card's bus handshake, reset and watchdog.
// Bound to the card; the host holds each strobe until acknowledge.
`timescale 1ns/1ps
module qeac_chk
  import qeac_pkg::*;
#(
  parameter int WD_CYCLES = 50
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_clk_en,
  // Bus
  input wire logic [15:0] i_bus_addr,
  input wire logic [15:0] i_bus_data,
  input wire logic i_bus_valid,
  input wire logic i_bus_rd,
  input wire logic i_bus_wr,
  input wire logic i_bus_reset,
  input wire logic [15:0] o_bus_data,
  input wire logic o_bus_data_oe,
  input wire logic o_bus_rdy,
  // Straps, encoders, machine side
  input wire logic [7:0] i_base_addr_switch,
  input wire logic i_wd_mode_strap,
  input wire logic i_probe_polarity_strap,
  input wire logic [AXIS_N-1:0][1:0] i_count_mode,
  input wire qeac_enc_type [AXIS_N-1:0] i_axis_enc,
  input wire logic i_probe_trigger_in,
  input wire logic o_health_led,
  input wire logic [AXIS_N-1:0][15:0] o_set_value
);
  default clocking @(posedge i_clk);
  endclocking
  default disable iff (i_sys_rst);
  ////////////////////////////////////////////////////////////
  // Only actual-value reads may feed the watchdog
  wire hit = i_bus_addr[15:13] == AREA_CODE && i_bus_addr[12:5] == i_base_addr_switch;
  wire act_rd = i_bus_valid && i_bus_rd && hit && i_bus_addr[2:0] == {FN_ACTUAL, 1'b0};
  int unsigned idle_q;
  always_ff @(posedge i_clk) begin
    idle_q <= (i_sys_rst || act_rd) ? 0 : idle_q + 1;
  end
  ////////////////////////////////////////////////////////////
  chk_ack_cause: assert property ($rose(o_bus_rdy) |-> $past(i_bus_valid, 2))
    else $error("ack without a held request");
  chk_ack_timely: assert property (
    $rose(i_bus_valid) && (i_bus_rd || i_bus_wr) && hit && !i_bus_addr[0] |-> ##[2:8] o_bus_rdy)
    else $error("mapped access not acknowledged");
  chk_refuse_bad: assert property (
    $rose(i_bus_valid) && (!hit || i_bus_addr[0]) ##1 i_bus_valid [*7] |-> !o_bus_rdy)
    else $error("foreign access acknowledged");
  chk_oe_read: assert property ($rose(o_bus_data_oe) |-> o_bus_rdy && $past(i_bus_rd, 2))
    else $error("data driven outside a read");
  chk_ack_stand: assert property (
    o_bus_rdy && i_bus_valid |=> o_bus_rdy && $stable(o_bus_data))
    else $error("answer changed while request held");
  chk_ack_drop: assert property ($fell(i_bus_valid) |-> ##[1:5] !o_bus_rdy)
    else $error("ack stuck after request dropped");
  chk_reset_out: assert property ($fell(i_sys_rst) |-> o_set_value == '0 && o_health_led)
    else $error("outputs wrong after reset");
  chk_trip_clear: assert property ($fell(o_health_led) |-> ##[0:2] o_set_value == '0)
    else $error("set values kept after trip");
  chk_wd_timeout: assert property (
    !i_wd_mode_strap && idle_q > WD_CYCLES + 8 |-> !o_health_led)
    else $error("watchdog did not trip");
  cov_read: cover property (o_bus_rdy && o_bus_data_oe);
  cov_trip: cover property ($fell(o_health_led));
  cov_refuse: cover property (i_bus_valid && i_bus_addr[0]);
endmodule : qeac_chk

bind qeac_axis_card qeac_chk #(.WD_CYCLES(WD_CYCLES)) u_chk (.*);

// >>> bench/qeac_host.sv
// Host processor model: one bus read or write per call of acc.
// Assumes the card answers within 20 clocks; released lines show inverse.
`timescale 1ns/1ps
module qeac_host (
  // Clock
  input wire logic i_clk,
  // Request pins
  output logic [15:0] o_addr,
  output logic [15:0] o_data,
  output logic o_valid,
  output logic o_rd,
  output logic o_wr,
  // Answer pins
  input wire logic [15:0] i_rdata,
  input wire logic i_rdy
);
  initial begin
    o_addr = 16'h0000;
    o_data = 16'h0000;
    o_valid = 1'b0;
    o_rd = 1'b0;
    o_wr = 1'b0;
  end
  task automatic acc(input logic w, input logic [15:0] a, input logic [15:0] wd,
                     output logic [15:0] rd, output logic ack);
    int n;
    rd = 16'h0000;
    ack = 1'b0;
    @(posedge i_clk);
    o_addr <= a;
    o_data <= wd;
    o_wr <= w;
    o_rd <= !w;
    o_valid <= 1'b1;
    for (n = 0; n < 20 && !ack; n++) begin
      @(posedge i_clk);
      ack = (i_rdy === 1'b1);
      rd = i_rdata;
    end
    // Released lines must not keep the old value
    o_valid <= 1'b0;
    o_rd <= 1'b0;
    o_wr <= 1'b0;
    o_addr <= ~a;
    o_data <= ~wd;
    for (n = 0; n < 10 && i_rdy !== 1'b0; n++) begin
      @(posedge i_clk);
    end
    @(posedge i_clk);
  endtask : acc
endmodule : qeac_host

// >>> bench/testbench.sv
// Self-checking bench for the four-axis encoder card.
// Assumes the host model for bus cycles and the bound checker.
`timescale 1ns/1ps
module testbench import qeac_pkg::*; ;
  localparam int WD = 200;
  localparam logic [7:0] SW = 8'h28;
  logic i_clk, i_sys_rst, i_clk_en, i_bus_valid, i_bus_rd, i_bus_wr, i_bus_reset;
  logic [15:0] i_bus_addr, i_bus_data, o_bus_data, d;
  logic o_bus_data_oe, o_bus_rdy, i_wd_mode_strap, i_probe_polarity_strap, k;
  logic i_probe_trigger_in, o_health_led;
  logic [7:0] i_base_addr_switch;
  logic [AXIS_N-1:0][1:0] i_count_mode;
  qeac_enc_type [AXIS_N-1:0] i_axis_enc;
  logic [AXIS_N-1:0][15:0] o_set_value;
  int fails;
  int compares;
  qeac_axis_card #(.WD_CYCLES(WD)) dut (.*);
  qeac_host host (.i_clk(i_clk), .o_addr(i_bus_addr), .o_data(i_bus_data),
    .o_valid(i_bus_valid), .o_rd(i_bus_rd), .o_wr(i_bus_wr), .i_rdata(o_bus_data),
    .i_rdy(o_bus_rdy));
  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end
  ////////////////////////////////////////////////////////////
  function automatic logic [15:0] adr(input int ax, input logic [1:0] fn);
    return {AREA_CODE, SW, 2'(ax), fn, 1'b0};
  endfunction : adr
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Read compares data, write only the acknowledge
  task automatic xf(input logic w, input int ax, input logic [1:0] fn, input logic [15:0] v);
    host.acc(w, adr(ax, fn), v, d, k);
    chk({15'h0000, k}, 16'h0001);
    if (!w) chk(d, v);
  endtask : xf
  task automatic nak(input logic [15:0] a);
    host.acc(1'b0, a, 16'h0000, d, k);
    chk({15'h0000, k}, 16'h0000);
  endtask : nak
  task automatic wt(input int n);
    repeat (n) @(posedge i_clk);
  endtask : wt
  // Axes 0..2 see quadrature; axis 3 keeps its gate track high
  task automatic cyc(input logic up, input int n);
    logic [7:0] s;
    s = up ? 8'hB4 : 8'h78;
    repeat (n) begin
      for (int i = 3; i >= 0; i--) begin
        for (int j = 0; j < 3; j++) i_axis_enc[j][1:0] <= {s[2*i], s[2*i+1]};
        i_axis_enc[3].track_a <= s[2*i+1];
        wt(4);
      end
    end
  endtask : cyc
  task automatic close_out();
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : close_out
  initial begin
    wt(20000);
    fails++;
    close_out();
  end
  ////////////////////////////////////////////////////////////
  initial begin
    i_sys_rst = 1'b1;
    i_clk_en = 1'b1;
    i_bus_reset = 1'b0;
    i_base_addr_switch = SW;
    i_wd_mode_strap = 1'b0;
    i_probe_polarity_strap = 1'b1;
    i_probe_trigger_in = 1'b0;
    i_count_mode = {MODE_COUNTER, MODE_SINGLE_A, MODE_DOUBLE_A, MODE_QUAD4};
    i_axis_enc = '0;
    i_axis_enc[3].track_b = 1'b1;
    fails = 0;
    compares = 0;
    wt(5);
    i_sys_rst <= 1'b0;
    for (int ax = 0; ax < AXIS_N; ax++) xf(0, ax, FN_ACTUAL, 16'h0000);
    host.acc(1'b0, adr(0, FN_MEAS), 16'h0000, d, k);
    xf(0, 0, FN_STATUS, 16'h0000);
    nak(adr(0, FN_STATUS) | 16'h0001);
    nak(adr(1, FN_STATUS) ^ 16'h0020);
    i_axis_enc[1][5:3] <= 3'h7;
    wt(4);
    xf(0, 1, FN_STATUS, 16'h0070);
    i_axis_enc[1][5:3] <= 3'h0;
    cyc(1'b0, 1);
    xf(0, 0, FN_ACTUAL, 16'hFFFC);
    xf(0, 1, FN_ACTUAL, 16'hFFFE);
    xf(0, 2, FN_ACTUAL, 16'hFFFF);
    cyc(1'b1, 2);
    xf(0, 0, FN_ACTUAL, 16'h0004);
    xf(0, 0, FN_ACTUAL, 16'h0004);
    xf(0, 3, FN_ACTUAL, 16'h0003);
    xf(0, 3, FN_ACTUAL, 16'h0000);
    i_axis_enc[3].track_b <= 1'b0;
    wt(4);
    i_axis_enc[3].track_b <= 1'b1;
    cyc(1'b1, 1);
    xf(0, 3, FN_ACTUAL, 16'h0000);
    i_bus_reset <= 1'b1;
    wt(4);
    i_bus_reset <= 1'b0;
    cyc(1'b1, 1);
    xf(0, 3, FN_ACTUAL, 16'h0001);
    xf(1, 2, FN_STATUS, 16'h0001);
    xf(0, 2, FN_STATUS, 16'h0000);
    i_axis_enc[0].zero_mark <= 1'b1;
    i_axis_enc[2].zero_mark <= 1'b1;
    wt(4);
    i_axis_enc[0].zero_mark <= 1'b0;
    i_axis_enc[2].zero_mark <= 1'b0;
    wt(4);
    xf(0, 2, FN_ACTUAL, 16'h0000);
    xf(0, 2, FN_STATUS, 16'h0002);
    xf(0, 0, FN_ACTUAL, 16'h0004);
    xf(1, 0, FN_STATUS, 16'h0004);
    i_probe_trigger_in <= 1'b1;
    wt(6);
    xf(0, 1, FN_STATUS, 16'h0008);
    cyc(1'b1, 1);
    xf(0, 0, FN_ACTUAL, 16'h0004);
    xf(0, 0, FN_MEAS, 16'h0004);
    xf(0, 0, FN_STATUS, 16'h0000);
    xf(0, 0, FN_ACTUAL, 16'h0008);
    xf(0, 1, FN_ACTUAL, 16'h0002);
    xf(1, 0, FN_STATUS, 16'h0004);
    xf(0, 1, FN_MEAS, 16'h0002);
    xf(0, 0, FN_MEAS, 16'h0008);
    i_probe_trigger_in <= 1'b0;
    wt(4);
    xf(1, 0, FN_STATUS, 16'h0004);
    host.acc(1'b0, adr(0, FN_MEAS), 16'h0000, d, k);
    i_probe_trigger_in <= 1'b1;
    wt(6);
    xf(0, 0, FN_STATUS, 16'h0000);
    xf(1, 1, FN_SET, 16'h1234);
    chk(o_set_value[1], 16'h1234);
    repeat (3) begin
      wt(90);
      host.acc(1'b0, adr(1, FN_MEAS), 16'h0000, d, k);
    end
    chk({15'h0000, o_health_led}, 16'h0000);
    chk(o_set_value[1], 16'h0000);
    xf(0, 0, FN_STATUS, 16'h0080);
    xf(0, 0, FN_ACTUAL, 16'h0008);
    wt(4);
    chk({15'h0000, o_health_led}, 16'h0001);
    i_wd_mode_strap <= 1'b1;
    wt(4);
    xf(1, 0, FN_STATUS, 16'h0000);
    wt(250);
    xf(0, 0, FN_ACTUAL, 16'h0008);
    wt(4);
    chk({15'h0000, o_health_led}, 16'h0000);
    xf(1, 0, FN_STATUS, 16'h0000);
    wt(4);
    chk({15'h0000, o_health_led}, 16'h0001);
    close_out();
  end
endmodule : testbench
